// File: pfr_adder.sv
// Flag-generating adder used for both addition and subtraction.
`timescale 1ns/10ps
`default_nettype none
`include "pfr_params.svh"
module pfr_adder #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    input wire logic sub,
    output logic [WIDTH-1:0] sum,
    output logic nib_carry,
    output logic msb_carry
);
    logic [WIDTH-1:0] b_eff;
    logic [WIDTH:0] full;
    logic [`PFR_NIB_W:0] low;

    // Elaboration check: the nibble carry needs more than four bits.
    if (WIDTH <= `PFR_NIB_W) begin : g_bad_width
        $error("pfr_adder WIDTH must exceed the nibble width.");
    end

    // Subtraction adds the two's complement of b; carries mean no borrow. [R05] [R06]
    assign b_eff = sub ? ~b : b;
    assign full = {1'b0, a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, sub};
    assign low = {1'b0, a[`PFR_NIB_W-1:0]} + {1'b0, b_eff[`PFR_NIB_W-1:0]}
        + {{`PFR_NIB_W{1'b0}}, sub};
    assign sum = full[WIDTH-1:0];
    assign nib_carry = low[`PFR_NIB_W]; // [R03]
    assign msb_carry = full[WIDTH]; // [R04]
endmodule
`default_nettype wire

// File: pfr_core_model.sv
// Processor core model that issues ALU operations to the flag register.
`timescale 1ns/10ps
`default_nettype none
module pfr_core_model (
    input wire logic clk,
    output pfr_pkg::pfr_op_e alu_op,
    output logic [7:0] alu_a,
    output logic [7:0] alu_b,
    output logic [7:0] logic_result
);
    // The core starts idle with no operation offered.
    initial begin
        alu_op = pfr_pkg::PFR_OP_NONE;
        alu_a = 8'h00;
        alu_b = 8'h00;
        logic_result = 8'h00;
    end

    // Offers one operation for one cycle, then idles with scrambled operands.
    task automatic run(input pfr_pkg::pfr_op_e op, input logic [7:0] a, input logic [7:0] b, input logic [7:0] lr);
        @(posedge clk);
        alu_op <= op;
        alu_a <= a;
        alu_b <= b;
        logic_result <= lr;
        @(posedge clk);
        alu_op <= pfr_pkg::PFR_OP_NONE;
        alu_a <= ~a;
        alu_b <= ~b;
        logic_result <= ~lr;
    endtask
endmodule
`default_nettype wire

// File: pfr_flag_reg.sv
// Processor flag register with ALU flag update and bank outputs.
// ----------------------------------------------------------------------
// What this block does
// R01: One 8-bit flag register answers at four addresses, one per bank.
// R02: Null flag bit 2 set on zero result, cleared otherwise.
// R03: Add/subtract sets nibble overflow bit 1 on carry out of bit 3.
// R04: Add/subtract sets msb overflow bit 0 on carry out of msb.
// R05: In subtraction both overflow flags mean no borrow when one.
// R06: Subtraction adds two's complement; flags come from that addition.
// R07: Bits 6-5 pick direct bank; bit 7 picks indirect bank pair.
// R08: Register writes never change watchdog expiry or sleep entered flags.
// R09: Flag-affecting op writing here keeps computed arithmetic flags.
// ----------------------------------------------------------------------
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "pfr_params.svh"
module pfr_flag_reg #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [`PFR_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire pfr_pkg::pfr_op_e alu_op,
    input wire logic [WIDTH-1:0] alu_a,
    input wire logic [WIDTH-1:0] alu_b,
    input wire logic [WIDTH-1:0] logic_result,
    output logic [WIDTH-1:0] alu_result,
    input wire logic wdog_expired,
    input wire logic sleep_entered,
    input wire logic cause_clear,
    output logic [1:0] direct_bank,
    output logic indirect_bank_hi
);
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [WIDTH-1:0] sum;
    logic nib_c;
    logic msb_c;
    logic hit;
    logic [WIDTH-1:0] res;

    // Elaboration check: the nibble overflow flag needs operands wider than a nibble.
    if (WIDTH <= `PFR_NIB_W) begin : g_bad_width
        $error("pfr_flag_reg WIDTH must exceed the nibble width.");
    end

    // ------------------------------------------------------------------
    // Address decode.
    // ------------------------------------------------------------------

    // Any of the four bank mirrors selects the same register.
    function automatic logic is_flag_addr(input logic [`PFR_ADDR_W-1:0] a);
        return a == `PFR_ADDR_BANK0 || a == `PFR_ADDR_BANK1 ||
               a == `PFR_ADDR_BANK2 || a == `PFR_ADDR_BANK3;
    endfunction

    assign hit = is_flag_addr(addr); // [R01]

    // ------------------------------------------------------------------
    // Arithmetic.
    // ------------------------------------------------------------------

    // Shared adder builds results and carry flags for add and subtract.
    pfr_adder #(.WIDTH(WIDTH)) u_adder (
        .a(alu_a),
        .b(alu_b),
        .sub(alu_op == pfr_pkg::PFR_OP_SUB), // [R06]
        .sum(sum),
        .nib_carry(nib_c),
        .msb_carry(msb_c)
    );

    // Result seen by the null flag and handed back to the core.
    always_comb begin
        case (alu_op)
            pfr_pkg::PFR_OP_ADD, pfr_pkg::PFR_OP_SUB: res = sum;
            pfr_pkg::PFR_OP_LOGIC: res = logic_result;
            default: res = logic_result;
        endcase
    end

    // Result output is registered.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            alu_result <= '0;
        end else begin
            alu_result <= res;
        end
    end

    // ------------------------------------------------------------------
    // Flag register next value.
    // ------------------------------------------------------------------

    // Software write first, then computed flags override, then cause flags.
    always_comb begin
        flags_next = flags_reg;
        if (wr && hit) begin
            // Cause bits keep their value on writes. [R08]
            flags_next = (wdata & ~`PFR_CAUSE_MASK) | (flags_reg & `PFR_CAUSE_MASK);
        end
        case (alu_op)
            pfr_pkg::PFR_OP_ADD, pfr_pkg::PFR_OP_SUB: begin
                flags_next[`PFR_BIT_NULL] = (res == '0); // [R02] [R09]
                flags_next[`PFR_BIT_NIB_OVF] = nib_c; // [R03] [R05]
                flags_next[`PFR_BIT_MSB_OVF] = msb_c; // [R04] [R05]
            end
            pfr_pkg::PFR_OP_LOGIC: begin
                flags_next[`PFR_BIT_NULL] = (res == '0); // [R02] [R09]
            end
            default: begin
            end
        endcase
        // A restore sets both cause flags; an expiry or sleep event in the same cycle wins.
        if (cause_clear) begin
            flags_next = flags_next | `PFR_CAUSE_MASK;
        end
        if (wdog_expired) begin
            flags_next[`PFR_BIT_WDOG] = 1'b0;
        end
        if (sleep_entered) begin
            flags_next[`PFR_BIT_SLEEP] = 1'b0;
        end
    end

    // Flag register state.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags_reg <= `PFR_RESET_VAL;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ------------------------------------------------------------------
    // Read port and bank outputs.
    // ------------------------------------------------------------------

    // Read data stand one cycle after the strobe; zero elsewhere.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (rd && hit) begin
            rdata <= flags_reg; // [R01]
        end else begin
            rdata <= 8'h00;
        end
    end

    // Bank selects drive the memory addressing logic. [R07]
    assign direct_bank = {flags_reg[`PFR_BIT_DBANK_HI], flags_reg[`PFR_BIT_DBANK_LO]};
    assign indirect_bank_hi = flags_reg[`PFR_BIT_IBANK];

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------

    property p_mirror_read;
        @(posedge clk) disable iff (!nrst)
        (rd && hit) |=> (rdata == $past(flags_reg));
    endproperty
    a_mirror_read: assert property (p_mirror_read) else $error("Mirror read wrong."); // [R01]

    property p_null;
        @(posedge clk) disable iff (!nrst)
        (alu_op != pfr_pkg::PFR_OP_NONE) |=> (flags_reg[`PFR_BIT_NULL] == (alu_result == '0));
    endproperty
    a_null: assert property (p_null) else $error("Null flag wrong."); // [R02]

    property p_nib;
        @(posedge clk) disable iff (!nrst)
        (alu_op == pfr_pkg::PFR_OP_ADD) |=>
            (flags_reg[`PFR_BIT_NIB_OVF] ==
             (({1'b0, $past(alu_a[`PFR_NIB_W-1:0])} + {1'b0, $past(alu_b[`PFR_NIB_W-1:0])}) > 5'h0F));
    endproperty
    a_nib: assert property (p_nib) else $error("Nibble overflow wrong."); // [R03]

    property p_msb;
        @(posedge clk) disable iff (!nrst)
        (alu_op == pfr_pkg::PFR_OP_ADD) |=>
            (flags_reg[`PFR_BIT_MSB_OVF] == (({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)}) > {1'b0, {WIDTH{1'b1}}}));
    endproperty
    a_msb: assert property (p_msb) else $error("Msb overflow wrong."); // [R04]

    property p_borrow;
        @(posedge clk) disable iff (!nrst)
        (alu_op == pfr_pkg::PFR_OP_SUB) |=> (flags_reg[`PFR_BIT_MSB_OVF] == ($past(alu_a) >= $past(alu_b)));
    endproperty
    a_borrow: assert property (p_borrow) else $error("Borrow polarity wrong."); // [R05]

    property p_sub_result;
        @(posedge clk) disable iff (!nrst)
        (alu_op == pfr_pkg::PFR_OP_SUB) |=> (alu_result == WIDTH'($past(alu_a) - $past(alu_b)));
    endproperty
    a_sub_result: assert property (p_sub_result) else $error("Subtract result wrong."); // [R06]

    property p_bank;
        @(posedge clk) disable iff (!nrst)
        (wr && hit) |=>
            (direct_bank == $past(wdata[`PFR_BIT_DBANK_HI:`PFR_BIT_DBANK_LO]) &&
             indirect_bank_hi == $past(wdata[`PFR_BIT_IBANK]));
    endproperty
    a_bank: assert property (p_bank) else $error("Bank select wrong."); // [R07]

    property p_cause_kept;
        @(posedge clk) disable iff (!nrst)
        (wr && !cause_clear && !wdog_expired && !sleep_entered) |=> $stable(flags_reg[`PFR_BIT_WDOG:`PFR_BIT_SLEEP]);
    endproperty
    a_cause_kept: assert property (p_cause_kept) else $error("Cause flag written."); // [R08]

    property p_override;
        @(posedge clk) disable iff (!nrst)
        (wr && hit && alu_op == pfr_pkg::PFR_OP_ADD) |=>
            (flags_reg[`PFR_BIT_MSB_OVF] == (({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)}) > {1'b0, {WIDTH{1'b1}}}));
    endproperty
    a_override: assert property (p_override) else $error("Written flag not overridden."); // [R09]

    // ------------------------------------------------------------------
    // Access and update sequences, with the checks built on them.
    // ------------------------------------------------------------------

    // A read strobe at an address that none of the mirrors answers.
    sequence s_miss_read;
        rd && !hit;
    endsequence

    // A hit read followed by a cycle without a read strobe.
    sequence s_read_once;
        (rd && hit) ##1 !rd;
    endsequence

    // A hit write with no operation and no cause event beside it.
    sequence s_plain_write;
        wr && hit && alu_op == pfr_pkg::PFR_OP_NONE && !cause_clear && !wdog_expired && !sleep_entered;
    endsequence

    // A missed write with no operation and no cause event beside it.
    sequence s_miss_write;
        wr && !hit && alu_op == pfr_pkg::PFR_OP_NONE && !cause_clear && !wdog_expired && !sleep_entered;
    endsequence

    // A cycle in which nothing may touch the register.
    sequence s_idle;
        !wr && alu_op == pfr_pkg::PFR_OP_NONE && !cause_clear && !wdog_expired && !sleep_entered;
    endsequence

    // Reads away from the mirrors return zero.
    property p_miss_read;
        @(posedge clk) disable iff (!nrst)
        s_miss_read |=> (rdata == 8'h00);
    endproperty
    a_miss_read: assert property (p_miss_read) else $error("Unmapped read not zero."); // [R01]

    // Read data stand for one cycle only and then return to zero.
    property p_read_once;
        @(posedge clk) disable iff (!nrst)
        s_read_once |=> (rdata == 8'h00);
    endproperty
    a_read_once: assert property (p_read_once) else $error("Read data held too long."); // [R01]

    // A plain write lands everywhere except in the cause flags.
    property p_plain_write;
        @(posedge clk) disable iff (!nrst)
        s_plain_write |=>
            (flags_reg == (($past(wdata) & ~`PFR_CAUSE_MASK) | ($past(flags_reg) & `PFR_CAUSE_MASK)));
    endproperty
    a_plain_write: assert property (p_plain_write) else $error("Plain write wrong."); // [R08]

    // A write away from the mirrors leaves the register alone.
    property p_miss_write;
        @(posedge clk) disable iff (!nrst)
        s_miss_write |=> $stable(flags_reg);
    endproperty
    a_miss_write: assert property (p_miss_write) else $error("Unmapped write changed flags."); // [R01]

    // With no write, operation or event the register holds.
    property p_idle_hold;
        @(posedge clk) disable iff (!nrst)
        s_idle |=> $stable(flags_reg);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("Flags changed while idle."); // [R02]

    // In subtraction the nibble flag is one when the low nibble needs no borrow.
    property p_nib_sub;
        @(posedge clk) disable iff (!nrst)
        (alu_op == pfr_pkg::PFR_OP_SUB) |=>
            (flags_reg[`PFR_BIT_NIB_OVF] == ($past(alu_a[`PFR_NIB_W-1:0]) >= $past(alu_b[`PFR_NIB_W-1:0])));
    endproperty
    a_nib_sub: assert property (p_nib_sub) else $error("Nibble borrow polarity wrong."); // [R05]

    // A logic operation sets the null flag from the core's own result.
    property p_logic_null;
        @(posedge clk) disable iff (!nrst)
        (alu_op == pfr_pkg::PFR_OP_LOGIC) |=> (flags_reg[`PFR_BIT_NULL] == ($past(logic_result) == '0));
    endproperty
    a_logic_null: assert property (p_logic_null) else $error("Logic null flag wrong."); // [R02]

    // A logic operation leaves both overflow flags alone.
    property p_logic_carry_hold;
        @(posedge clk) disable iff (!nrst)
        (alu_op == pfr_pkg::PFR_OP_LOGIC && !(wr && hit)) |=>
            $stable(flags_reg[`PFR_BIT_NIB_OVF:`PFR_BIT_MSB_OVF]);
    endproperty
    a_logic_carry_hold: assert property (p_logic_carry_hold) else $error("Logic op touched carries."); // [R03]

    // Only a hit write moves the bank selects.
    property p_bank_hold;
        @(posedge clk) disable iff (!nrst)
        !(wr && hit) |=> $stable(flags_reg[`PFR_BIT_IBANK:`PFR_BIT_DBANK_LO]);
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("Bank select moved without write."); // [R07]

    // A write beside an addition still gets the computed null flag.
    property p_override_null;
        @(posedge clk) disable iff (!nrst)
        (wr && hit && alu_op == pfr_pkg::PFR_OP_ADD) |=>
            (flags_reg[`PFR_BIT_NULL] == (WIDTH'($past(alu_a) + $past(alu_b)) == '0));
    endproperty
    a_override_null: assert property (p_override_null) else $error("Written null flag kept."); // [R09]

    // An expiry event always leaves the watchdog flag cleared.
    property p_wdog_event;
        @(posedge clk) disable iff (!nrst)
        wdog_expired |=> !flags_reg[`PFR_BIT_WDOG];
    endproperty
    a_wdog_event: assert property (p_wdog_event) else $error("Expiry event lost."); // [R08]
endmodule
`default_nettype wire

// File: pfr_params.svh
// Constants for the processor flag register block.
`ifndef PFR_PARAMS_SVH
`define PFR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register addresses.
// ----------------------------------------------------------------------
`define PFR_ADDR_BANK0 9'h003
`define PFR_ADDR_BANK1 9'h083
`define PFR_ADDR_BANK2 9'h103
`define PFR_ADDR_BANK3 9'h183
`define PFR_ADDR_W 9

// ----------------------------------------------------------------------
// Bit positions.
// ----------------------------------------------------------------------
`define PFR_BIT_MSB_OVF 0
`define PFR_BIT_NIB_OVF 1
`define PFR_BIT_NULL 2
`define PFR_BIT_SLEEP 3
`define PFR_BIT_WDOG 4
`define PFR_BIT_DBANK_LO 5
`define PFR_BIT_DBANK_HI 6
`define PFR_BIT_IBANK 7

// ----------------------------------------------------------------------
// Reset values and masks.
// ----------------------------------------------------------------------
`define PFR_RESET_VAL 8'h18
`define PFR_ARITH_MASK 8'h07
`define PFR_CAUSE_MASK 8'h18
`define PFR_NIB_W 4

`endif

// File: pfr_pkg.sv
// Types shared by the processor flag register block.
`default_nettype none
package pfr_pkg;
    typedef enum logic [1:0] {
        PFR_OP_NONE = 2'h0,
        PFR_OP_ADD = 2'h1,
        PFR_OP_SUB = 2'h3,
        PFR_OP_LOGIC = 2'h2
    } pfr_op_e;
endpackage
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the processor flag register.
`timescale 1ns/10ps
`default_nettype none
`include "pfr_params.svh"
module tb_top;
    logic clk, nrst, wr, rd, wdog_expired, sleep_entered, cause_clear, indirect_bank_hi;
    logic [8:0] addr;
    logic [7:0] wdata, rdata, alu_a, alu_b, logic_result, alu_result, exp_reg, res;
    logic [1:0] direct_bank;
    pfr_pkg::pfr_op_e alu_op;
    int fail_count, n_tests, cycles;
    logic [8:0] bank_addr [4] = '{`PFR_ADDR_BANK0, `PFR_ADDR_BANK1, `PFR_ADDR_BANK2, `PFR_ADDR_BANK3};
    pfr_pkg::pfr_op_e ops [7] = '{pfr_pkg::PFR_OP_ADD, pfr_pkg::PFR_OP_ADD, pfr_pkg::PFR_OP_SUB,
        pfr_pkg::PFR_OP_SUB, pfr_pkg::PFR_OP_SUB, pfr_pkg::PFR_OP_LOGIC, pfr_pkg::PFR_OP_NONE};
    logic [7:0] av [7] = '{8'h0F, 8'hFF, 8'h05, 8'h10, 8'h01, 8'h33, 8'h44};
    logic [7:0] bv [7] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h02, 8'hCC, 8'h44};
    logic [7:0] lv [7] = '{8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h00, 8'h00};

    pfr_flag_reg #(.WIDTH(8)) i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .logic_result(logic_result),
        .alu_result(alu_result), .wdog_expired(wdog_expired), .sleep_entered(sleep_entered),
        .cause_clear(cause_clear), .direct_bank(direct_bank), .indirect_bank_hi(indirect_bank_hi));
    pfr_core_model i_core (.clk(clk), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
        .logic_result(logic_result));

    // ----------------------------------------------------------------------
    // Helpers.
    // ----------------------------------------------------------------------
    // Expected result and flags; subtraction adds the inverted subtrahend plus one.
    function automatic logic [15:0] calc(pfr_pkg::pfr_op_e op, logic [7:0] a, logic [7:0] b,
        logic [7:0] lr, logic [7:0] st);
        logic sub;
        logic [8:0] s;
        logic [4:0] n;
        sub = (op == pfr_pkg::PFR_OP_SUB);
        s = {1'b0, a} + {1'b0, sub ? ~b : b} + {8'h00, sub};
        n = {1'b0, a[3:0]} + {1'b0, sub ? ~b[3:0] : b[3:0]} + {4'h0, sub};
        if (op == pfr_pkg::PFR_OP_LOGIC) begin
            st[2] = (lr == 8'h00);
        end else if (op != pfr_pkg::PFR_OP_NONE) begin
            st[2:0] = {s[7:0] == 8'h00, n[4], s[8]};
        end
        return {s[7:0], st};
    endfunction

    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Clock and hang guard.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            results();
        end
    end

    // Main sequence.
    initial begin
        {nrst, wr, rd, wdog_expired, sleep_entered, cause_clear} = 6'h00;
        addr = 9'h000;
        wdata = 8'h00;
        exp_reg = `PFR_RESET_VAL;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 4; k++) rd_chk(bank_addr[k], exp_reg);
        rd_chk(9'h004, 8'h00);
        wr_reg(9'h004, 8'hFF);
        rd_chk(bank_addr[0], exp_reg);
        for (int k = 0; k < 4; k++) begin
            wr_reg(bank_addr[k], {k[0], k[1:0], 5'h05});
            exp_reg = {k[0], k[1:0], exp_reg[4:3], 3'h5};
            #1; // Bank outputs follow the register only after the write edge has settled.
            chk("direct_bank", {6'h00, k[1:0]}, {6'h00, direct_bank});
            chk("indirect_bank_hi", {7'h00, k[0]}, {7'h00, indirect_bank_hi});
            rd_chk(bank_addr[(k + 1) % 4], exp_reg);
        end
        @(posedge clk);
        wdog_expired <= 1'b1;
        @(posedge clk);
        wdog_expired <= 1'b0;
        sleep_entered <= 1'b1;
        @(posedge clk);
        sleep_entered <= 1'b0;
        wr_reg(bank_addr[2], 8'hFF);
        exp_reg = 8'hE7;
        rd_chk(bank_addr[3], exp_reg);
        // A restore and an expiry in one cycle: the expiry wins, then a lone restore.
        @(posedge clk);
        cause_clear <= 1'b1;
        wdog_expired <= 1'b1;
        @(posedge clk);
        cause_clear <= 1'b0;
        wdog_expired <= 1'b0;
        exp_reg = 8'hEF;
        rd_chk(bank_addr[1], exp_reg);
        @(posedge clk);
        cause_clear <= 1'b1;
        @(posedge clk);
        cause_clear <= 1'b0;
        exp_reg = 8'hFF;
        rd_chk(bank_addr[2], exp_reg);
        for (int k = 0; k < 7; k++) begin
            {res, exp_reg} = calc(ops[k], av[k], bv[k], lv[k], exp_reg);
            i_core.run(ops[k], av[k], bv[k], lv[k]);
            #1;
            if (ops[k] inside {pfr_pkg::PFR_OP_ADD, pfr_pkg::PFR_OP_SUB}) begin
                chk("alu_result", res, alu_result);
            end
            rd_chk(bank_addr[k % 4], exp_reg);
        end
        // Write and flag-affecting operation land on the same edge.
        {res, exp_reg} = calc(pfr_pkg::PFR_OP_ADD, 8'h80, 8'h80, 8'h00, {3'h0, exp_reg[4:3], 3'h2});
        fork
            i_core.run(pfr_pkg::PFR_OP_ADD, 8'h80, 8'h80, 8'h00);
            wr_reg(bank_addr[1], 8'h02);
        join
        rd_chk(bank_addr[0], exp_reg);
        chk("direct_bank", 8'h00, {6'h00, direct_bank});
        results();
    end
endmodule
`default_nettype wire
